// ==== sfw_top.sv ====
// Purpose: Shared byte buffer between host registers and the internal command engine.
// Assumes: APB slave with one wait state; engine logic runs on pclk.
// Notes:   Engine data wins when both push in one cycle; when both pop in one cycle, both get the same byte.
//
// Behaviour
// - One buffer shared by host and engine.
// - Clear bit resets pointers and count.
// - Capacity 512, or 255 when selected.
// - Count rises on write, falls on read.
// - One nine-bit threshold serves both alerts.
// - Near-full when free space within threshold.
// - Near-empty when count within threshold.
// - Write while full sets overflow, error interrupt.
// - Enabled near-empty rise activates interrupt.
// - Enabled near-full rise activates interrupt.
// - Bytes eight bits, depth 512.
// - Count needs ten bits, threshold nine.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "sfw_consts.svh"
module sfw_top
   import sfw_pkg::*;
#(
   parameter int DEPTH  = 512,
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              eng_push,
   input  wire logic [7:0]        eng_wdata,
   input  wire logic              eng_pop,
   output logic      [7:0]        eng_rdata,
   output logic                   eng_rdata_valid,
   output logic                   eng_full,
   output logic                   eng_empty,
   output logic                   eng_overflow,
   output logic                   irq
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH != 512) begin
         $error("sfw_top serves a depth of 512 bytes only");
      end
      if (ADDR_W < 6) begin
         $error("sfw_top needs at least six address bits");
      end
   end

   // ****************************************************************
   // State
   // ****************************************************************
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   sfw_count_t    count;
   sfw_cfg_t      cfg;
   logic          overflow;
   sfw_irq_t      int_status;
   sfw_irq_t      int_enable;
   logic [7:0]    mem_q;
   logic          near_full;
   logic          near_empty;
   logic          near_full_rise;
   logic          near_empty_rise;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   logic              access;
   logic              done;
   logic [ADDR_W-3:0] idx;
   logic              aligned;
   logic              hit_ctrl;
   logic              hit_thr;
   logic              hit_fill;
   logic              hit_data;
   logic              hit_stat;
   logic              hit_clr;
   logic              hit_en;
   logic              mapped;
   logic              wr_ok;

   always_comb begin
      access   = psel && penable;
      done     = access && pready;
      idx      = paddr[ADDR_W-1:2];
      aligned  = paddr[1:0] == 2'b00;
      hit_ctrl = aligned && (idx == (ADDR_W-2)'(`SFW_IDX_CTRL));
      hit_thr  = aligned && (idx == (ADDR_W-2)'(`SFW_IDX_THRESHOLD));
      hit_fill = aligned && (idx == (ADDR_W-2)'(`SFW_IDX_FILL));
      hit_data = aligned && (idx == (ADDR_W-2)'(`SFW_IDX_DATA));
      hit_stat = aligned && (idx == (ADDR_W-2)'(`SFW_IDX_INT_STAT));
      hit_clr  = aligned && (idx == (ADDR_W-2)'(`SFW_IDX_INT_CLR));
      hit_en   = aligned && (idx == (ADDR_W-2)'(`SFW_IDX_INT_EN));
      mapped   = hit_ctrl || hit_thr || hit_fill || hit_data || hit_stat || hit_clr || hit_en;
      wr_ok    = done && pwrite && pstrb[0];
   end

   // ****************************************************************
   // Buffer movement
   // ****************************************************************
   sfw_count_t cap;
   logic       full;
   logic       empty;
   logic       clear;
   logic       host_push;
   logic       host_pop;
   logic       push_req;
   logic       pop_req;
   logic       push;
   logic       pop;
   logic [7:0] push_data;
   sfw_count_t next_count;
   sfw_cfg_t   next_cfg;
   sfw_count_t next_cap;

   always_comb begin
      cap       = cfg.cap_sel ? `SFW_CAP_REDUCED : `SFW_CAP_FULL;
      full      = count >= cap;
      empty     = count == '0;
      clear     = wr_ok && hit_ctrl && pwdata[`SFW_CTRL_CLEAR];
      host_push = wr_ok && hit_data;
      host_pop  = done && !pwrite && hit_data;
      push_req  = eng_push || host_push;
      pop_req   = eng_pop || host_pop;
      push_data = eng_push ? eng_wdata : pwdata[7:0];
      push      = push_req && !full && !clear;
      pop       = pop_req && !empty && !clear;
      next_count = count;
      if (clear) begin
         next_count = '0;
      end else if (push && !pop) begin
         next_count = count + 10'h001;
      end else if (pop && !push) begin
         next_count = count - 10'h001;
      end
      next_cfg = cfg;
      if (wr_ok && hit_ctrl) begin
         next_cfg.cap_sel = pwdata[`SFW_CTRL_CAP_SEL];
         next_cfg.thr[8]  = pwdata[`SFW_CTRL_THR_HI];
      end
      if (wr_ok && hit_thr) begin
         next_cfg.thr[7:0] = pwdata[7:0];
      end
      next_cap = next_cfg.cap_sel ? `SFW_CAP_REDUCED : `SFW_CAP_FULL;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count     <= '0;
         eng_full  <= 1'b0;
         eng_empty <= 1'b1;
      end else begin
         count     <= next_count;
         eng_full  <= next_count >= next_cap;
         eng_empty <= next_count == '0;
      end
   end

   logic [AW-1:0] next_rd_ptr;

   always_comb begin
      next_rd_ptr = rd_ptr;
      if (clear) begin
         next_rd_ptr = '0;
      end else if (pop) begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
   end

   sfw_mem #(
      .WIDTH (8),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_mem (
      .pclk  (pclk),
      .we    (push),
      .waddr (wr_ptr),
      .wdata (push_data),
      .raddr (next_rd_ptr),
      .q     (mem_q)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eng_rdata       <= 8'h00;
         eng_rdata_valid <= 1'b0;
      end else begin
         eng_rdata_valid <= eng_pop && pop;
         if (eng_pop && pop) begin
            eng_rdata <= mem_q;
         end
      end
   end

   // ****************************************************************
   // Configuration and overflow
   // ****************************************************************
   logic overflow_evt;

   always_comb begin
      overflow_evt = push_req && full && !clear;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '{cap_sel: 1'b0, thr: `SFW_RST_THRESHOLD};
      end else begin
         cfg <= next_cfg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow     <= 1'b0;
         eng_overflow <= 1'b0;
      end else begin
         eng_overflow <= overflow_evt && eng_push;
         if (overflow_evt) begin
            overflow <= 1'b1;
         end else if (clear) begin
            overflow <= 1'b0;
         end
      end
   end

   sfw_alert u_alert (
      .pclk            (pclk),
      .presetn         (presetn),
      .count           (count),
      .cfg             (cfg),
      .near_full       (near_full),
      .near_empty      (near_empty),
      .near_full_rise  (near_full_rise),
      .near_empty_rise (near_empty_rise)
   );

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   sfw_irq_t int_set;
   sfw_irq_t int_clr;
   sfw_irq_t next_status;
   sfw_irq_t next_enable;

   always_comb begin
      int_set.error      = overflow_evt;
      int_set.near_empty = near_empty_rise;
      int_set.near_full  = near_full_rise;
      int_clr            = (wr_ok && hit_clr) ? sfw_irq_t'(pwdata[2:0]) : sfw_irq_t'(3'h0);
      next_status        = int_set | (int_status & ~int_clr);
      next_enable        = (wr_ok && hit_en) ? sfw_irq_t'(pwdata[2:0]) : int_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_status <= '0;
         int_enable <= sfw_irq_t'(`SFW_RST_INT_EN);
         irq        <= 1'b0;
      end else begin
         int_status <= next_status;
         int_enable <= next_enable;
         irq        <= |(next_status & next_enable);
      end
   end

   // ****************************************************************
   // Bus answer
   // ****************************************************************
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[`SFW_CTRL_CAP_SEL]    = cfg.cap_sel;
         rd_mux[`SFW_CTRL_THR_HI]     = cfg.thr[8];
         rd_mux[`SFW_CTRL_FILL_HI]    = count[8] | count[9];
         rd_mux[`SFW_CTRL_OVERFLOW]   = overflow;
         rd_mux[`SFW_CTRL_NEAR_EMPTY] = near_empty;
         rd_mux[`SFW_CTRL_NEAR_FULL]  = near_full;
      end else if (hit_thr) begin
         rd_mux[7:0] = cfg.thr[7:0];
      end else if (hit_fill) begin
         rd_mux[7:0] = count[9] ? 8'hff : count[7:0];
      end else if (hit_data) begin
         rd_mux[7:0] = empty ? 8'h00 : mem_q;
      end else if (hit_stat) begin
         rd_mux[2:0] = int_status;
      end else if (hit_en) begin
         rd_mux[2:0] = int_enable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access && !pready;
         pslverr <= access && !pready && !mapped;
         if (access && !pready && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end
endmodule

// ==== sfw_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the shared buffer.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef SFW_CONSTS_SVH
`define SFW_CONSTS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define SFW_IDX_CTRL      10'h002
`define SFW_IDX_THRESHOLD 10'h003
`define SFW_IDX_FILL      10'h004
`define SFW_IDX_DATA      10'h005
`define SFW_IDX_INT_STAT  10'h006
`define SFW_IDX_INT_CLR   10'h007
`define SFW_IDX_INT_EN    10'h008

// ****************************************************************
// Control register fields
// ****************************************************************
`define SFW_CTRL_CLEAR      0
`define SFW_CTRL_CAP_SEL    1
`define SFW_CTRL_THR_HI     2
`define SFW_CTRL_FILL_HI    3
`define SFW_CTRL_OVERFLOW   4
`define SFW_CTRL_NEAR_EMPTY 5
`define SFW_CTRL_NEAR_FULL  6

// ****************************************************************
// Interrupt register fields
// ****************************************************************
`define SFW_INT_ERROR      0
`define SFW_INT_NEAR_EMPTY 1
`define SFW_INT_NEAR_FULL  2

// ****************************************************************
// Capacities, reset values and timing counts
// ****************************************************************
`define SFW_CAP_FULL      10'h200
`define SFW_CAP_REDUCED   10'h0ff
`define SFW_RST_THRESHOLD 9'h000
`define SFW_RST_INT_EN    3'h0
`define SFW_WAIT_STATES   1

`endif

// ==== sfw_pkg.sv ====
// Purpose: Types shared by the buffer modules.
// Assumes: Threshold and fill count widths fit a 512 byte buffer.
// Notes:   Constants live in sfw_consts.svh.
package sfw_pkg;
   typedef logic [9:0] sfw_count_t;
   typedef struct packed {
      logic       cap_sel;
      logic [8:0] thr;
   } sfw_cfg_t;
   typedef struct packed {
      logic near_full;
      logic near_empty;
      logic error;
   } sfw_irq_t;
endpackage

// ==== sfw_mem.sv ====
// Purpose: Byte storage of the shared buffer with registered read data.
// Assumes: One write port and one read port on the same clock.
// Notes:   Write-first: a write to the address being read shows at once.
`timescale 1ns/1ps
module sfw_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 512,
   parameter int AW    = 9
) (
   input  wire logic             pclk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] store [DEPTH];

   initial begin
      if (DEPTH != (1 << AW)) begin
         $error("sfw_mem depth must equal two to the address width");
      end
   end

   // ****************************************************************
   // Write port
   // ****************************************************************
   always_ff @(posedge pclk) begin
      if (we) begin
         store[waddr] <= wdata;
      end
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   always_ff @(posedge pclk) begin
      if (we && (waddr == raddr)) begin
         q <= wdata;
      end else begin
         q <= store[raddr];
      end
   end
endmodule

// ==== sfw_alert.sv ====
// Purpose: Near-full and near-empty flags and their rising-edge events.
// Assumes: Fill count and configuration come from registers on pclk.
// Notes:   Flags follow the count one cycle later.
`timescale 1ns/1ps
`include "sfw_consts.svh"
module sfw_alert
   import sfw_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire sfw_count_t count,
   input  wire sfw_cfg_t   cfg,
   output logic            near_full,
   output logic            near_empty,
   output logic            near_full_rise,
   output logic            near_empty_rise
);
   sfw_count_t cap;
   logic       next_near_full;
   logic       next_near_empty;

   // ****************************************************************
   // Comparisons
   // ****************************************************************
   always_comb begin
      cap             = cfg.cap_sel ? `SFW_CAP_REDUCED : `SFW_CAP_FULL;
      next_near_full  = ({1'b0, count} + {2'b00, cfg.thr}) >= {1'b0, cap};
      next_near_empty = count <= {1'b0, cfg.thr};
   end

   // ****************************************************************
   // Flags and edges
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         near_full       <= 1'b0;
         near_empty      <= 1'b1;
         near_full_rise  <= 1'b0;
         near_empty_rise <= 1'b0;
      end else begin
         near_full       <= next_near_full;
         near_empty      <= next_near_empty;
         near_full_rise  <= next_near_full && !near_full;
         near_empty_rise <= next_near_empty && !near_empty;
      end
   end
endmodule

// ==== sfw_top_asserts.sv ====
// Purpose: Port assertions for sfw_top.
// Assumes: One pclk domain, presetn async active low.
// Notes:   Bound into every sfw_top instance.
`timescale 1ns/1ps
module sfw_top_asserts #(
   parameter int ADDR_W = 12
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              eng_push,
   input wire logic [7:0]        eng_wdata,
   input wire logic              eng_pop,
   input wire logic [7:0]        eng_rdata,
   input wire logic              eng_rdata_valid,
   input wire logic              eng_full,
   input wire logic              eng_empty,
   input wire logic              eng_overflow,
   input wire logic              irq
);
   // ****************************************************************
   // Port assertions
   // ****************************************************************
   logic hs;
   logic act;
   assign hs  = psel && penable && pready;
   assign act = hs || eng_push || eng_pop;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_PUSH_FILLS: assert property (eng_push && eng_empty && !hs |=> !eng_empty)
      else $error("push left buffer empty");
   AST_POP_GIVES_DATA: assert property (eng_pop && !eng_empty && !hs |=> eng_rdata_valid)
      else $error("pop gave no data");
   AST_VALID_CAUSE: assert property (eng_rdata_valid |-> $past(eng_pop) && !$past(eng_empty))
      else $error("data valid without pop");
   AST_EMPTY_POP: assert property (eng_pop && eng_empty |=> !eng_rdata_valid)
      else $error("pop from empty gave data");
   AST_FULL_NOT_EMPTY: assert property (eng_full |-> !eng_empty)
      else $error("full and empty together");
   AST_OVF_SET: assert property (eng_push && eng_full && !eng_pop && !hs |=> eng_overflow)
      else $error("refused push not flagged");
   AST_OVF_CAUSE: assert property (eng_overflow |-> $past(eng_push && eng_full))
      else $error("overflow without cause");
   AST_FULL_KEPT: assert property (eng_push && eng_full && !eng_pop && !hs |=> eng_full)
      else $error("refused push changed count");
   AST_IRQ_RISE: assert property ($rose(irq) |-> $past(act, 1) || $past(act, 2) || $past(act, 3))
      else $error("irq rose without cause");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(hs))
      else $error("irq fell without host write");
endmodule

bind sfw_top sfw_top_asserts #(.ADDR_W(ADDR_W)) u_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .eng_push(eng_push), .eng_wdata(eng_wdata), .eng_pop(eng_pop),
   .eng_rdata(eng_rdata), .eng_rdata_valid(eng_rdata_valid), .eng_full(eng_full),
   .eng_empty(eng_empty), .eng_overflow(eng_overflow), .irq(irq)
);

// ==== sfw_eng_model.sv ====
// Purpose: Command engine model on the engine side of the buffer.
// Assumes: Engine shares pclk and moves one byte per strobe.
// Notes:   Released write data shows the inverse of the last byte.
`timescale 1ns/1ps
module sfw_eng_model (
   input  wire logic       pclk,
   input  wire logic [7:0] eng_rdata,
   input  wire logic       eng_rdata_valid,
   output logic            eng_push,
   output logic [7:0]      eng_wdata,
   output logic            eng_pop
);
   initial begin
      eng_push = 1'b0;
      eng_wdata = 8'h00;
      eng_pop = 1'b0;
   end
   // Pushes one byte after an optional idle gap.
   task automatic push(input logic [7:0] d, input int gap);
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      eng_push  <= 1'b1;
      eng_wdata <= d;
      @(posedge pclk);
      eng_push  <= 1'b0;
      eng_wdata <= ~d;
   endtask
   // Pops one byte and takes the answer at the following edge.
   task automatic pop(output logic [7:0] d, output logic v);
      @(posedge pclk);
      eng_pop <= 1'b1;
      @(posedge pclk);
      eng_pop <= 1'b0;
      @(posedge pclk);
      v = eng_rdata_valid;
      d = eng_rdata;
   endtask
endmodule

// ==== sfw_top_tb.sv ====
// Purpose: Self-checking bench for sfw_top.
// Assumes: APB master tasks; engine side driven by sfw_eng_model.
// Notes:   Bytes and thresholds come from a fixed xorshift seed; the full-size test sets its threshold to 0x100.
`timescale 1ns/1ps
`include "sfw_consts.svh"
module sfw_top_tb
   import sfw_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, vld;
   logic        eng_push, eng_pop, eng_rdata_valid, eng_full, eng_empty, eng_overflow, irq, cs, ovf;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat, seed;
   logic [3:0]  pstrb;
   logic [7:0]  eng_wdata, eng_rdata, bt;
   logic [8:0]  thr;
   logic [7:0]  q[$];
   int          miscompares, cmp_count, cnt, i;

   sfw_top u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .eng_push(eng_push), .eng_wdata(eng_wdata), .eng_pop(eng_pop),
      .eng_rdata(eng_rdata), .eng_rdata_valid(eng_rdata_valid), .eng_full(eng_full),
      .eng_empty(eng_empty), .eng_overflow(eng_overflow), .irq(irq)
   );
   sfw_eng_model u_eng (
      .pclk(pclk), .eng_rdata(eng_rdata), .eng_rdata_valid(eng_rdata_valid),
      .eng_push(eng_push), .eng_wdata(eng_wdata), .eng_pop(eng_pop)
   );

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] exp_ctrl();
      int cap;
      cap = cs ? 255 : 512;
      return {25'h0, cnt + thr >= cap, cnt <= thr, ovf, cnt >= 256, thr[8], cs, 1'b0};
   endfunction
   function automatic logic [31:0] exp_fill();
      return {24'h0, (cnt == 512) ? 8'hff : cnt[7:0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_sig(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t signal %b expected %b", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rd(input logic [9:0] idx);
      apb(1'b0, idx, 32'h0);
   endtask
   task automatic state_chk();
      rd(`SFW_IDX_CTRL);
      chk(rdat, exp_ctrl());
      rd(`SFW_IDX_FILL);
      chk(rdat, exp_fill());
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      $display("BAD %0t watchdog expired", $time);
      print_verdict();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      seed = 32'hdd237d75;
      {miscompares, cmp_count, cnt} = '0;
      {presetn, psel, penable, pwrite, cs, ovf} = '0;
      {paddr, pwdata, thr} = '0;
      pstrb = 4'hf;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      state_chk();
      rd(`SFW_IDX_THRESHOLD);
      chk(rdat, 32'h0);
      rd(`SFW_IDX_INT_EN);
      chk(rdat, 32'h0);
      rd(10'h03f);
      chk({31'h0, rerr}, 32'h1);
      $display("test reset done");
      thr = 9'(rnd() % 30 + 2);
      wr(`SFW_IDX_THRESHOLD, {23'h0, thr});
      wr(`SFW_IDX_INT_EN, 32'h7);
      for (i = 0; i < thr + 4; i++) begin
         bt = 8'(rnd());
         wr(`SFW_IDX_DATA, {24'h0, bt});
         q.push_back(bt);
         cnt++;
         state_chk();
      end
      rd(`SFW_IDX_INT_STAT);
      chk(rdat, 32'h0);
      // Host stays off the data port while the engine drains.
      while (q.size() > 0) begin
         u_eng.pop(bt, vld);
         chk({24'h0, bt}, {24'h0, q.pop_front()});
         chk_sig(vld, 1'b1);
         cnt--;
      end
      state_chk();
      rd(`SFW_IDX_INT_STAT);
      chk(rdat, 32'h2);
      chk_sig(irq, 1'b1);
      wr(`SFW_IDX_INT_EN, 32'h0);
      repeat (4) @(posedge pclk);
      chk_sig(irq, 1'b0);
      wr(`SFW_IDX_INT_EN, 32'h7);
      repeat (4) @(posedge pclk);
      chk_sig(irq, 1'b1);
      wr(`SFW_IDX_INT_CLR, 32'h2);
      repeat (4) @(posedge pclk);
      chk_sig(irq, 1'b0);
      rd(`SFW_IDX_DATA);
      chk(rdat, 32'h0);
      u_eng.pop(bt, vld);
      chk_sig(vld, 1'b0);
      state_chk();
      $display("test host fill engine drain done");
      cs = 1'b1;
      thr = 9'(rnd() % 20 + 1);
      wr(`SFW_IDX_CTRL, 32'h2);
      wr(`SFW_IDX_THRESHOLD, {23'h0, thr});
      for (i = 0; i < 255; i++) begin
         bt = 8'(rnd());
         u_eng.push(bt, int'(rnd() % 3));
         cnt++;
      end
      @(posedge pclk);
      chk_sig(eng_full, 1'b1);
      wr(`SFW_IDX_DATA, 32'h5a);
      ovf = 1'b1;
      state_chk();
      rd(`SFW_IDX_INT_STAT);
      chk(rdat, 32'h5);
      chk_sig(irq, 1'b1);
      u_eng.push(8'ha5, 0);
      @(posedge pclk);
      chk_sig(eng_overflow, 1'b1);
      wr(`SFW_IDX_CTRL, 32'h3);
      {cnt, ovf} = '0;
      state_chk();
      chk_sig(eng_empty, 1'b1);
      wr(`SFW_IDX_INT_CLR, 32'h7);
      $display("test reduced mode done");
      cs = 1'b0;
      thr = 9'h100;
      wr(`SFW_IDX_THRESHOLD, 32'h0);
      wr(`SFW_IDX_CTRL, 32'h4);
      for (i = 1; i <= 512; i++) begin
         u_eng.push(8'(rnd()), 0);
         cnt++;
         if (i == 256 || i == 257 || i == 512)
            state_chk();
      end
      chk_sig(eng_full, 1'b1);
      wr(`SFW_IDX_CTRL, 32'h5);
      cnt = 0;
      state_chk();
      $display("test full size done");
      print_verdict();
   end
endmodule
